// >>> verilog/tdmsw_core.sv
// TDM time-slot interchange switch with host register port
//
// Operation
// - Any input channel of any stream can reach any output channel.
// - All streams share one programmed bit rate of 2, 4, 8 or 16 Mbps.
// - Single channels and Nx64k channel groups are both switched.
// - In bidirectional mode input is taken from the bidir pins.
// - Connection entries name a source stream and channel to send.
// - Message entries send their own host-written byte.
// - High impedance entries turn the driver off for that slot.
// - The host reads and writes registers and connection memory, and only reads data memory.
// - The host port has 16-bit data on a non-multiplexed address.
// - Each output channel picks constant or variable delay.
// - Each input stream has a bit delay and a sampling point.
// - Each output stream has whole and half bit advancement.
// - Two framing conventions differ in pulse polarity and edge.
// - Block programming fills all connection entries, one entry per clock.
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module tdmsw_core
  import tdmsw_pkg::*;
#(
  parameter int NS = NSTR
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADRW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [DW-1:0] rdata,
  input wire logic tdm_input_clock,
  input wire logic tdm_frame_pulse_in,
  input wire logic [NS-1:0] serial_in_stream,
  input wire logic [NS-1:0] serial_bidir_out_stream_pin,
  output logic [NS-1:0] serial_bidir_out_stream,
  output logic [NS-1:0] serial_bidir_out_stream_en
);
  localparam int SW = $clog2(NS);
  localparam int AW = SW + CHW;
  localparam int MD = NS << CHW;
  localparam int PW = $clog2(BUF_DEPTH);
  localparam int FW = 1 + AW + 8;

  logic [2:0] ck_s, fp_s;
  logic [NS-1:0] si_s1, si_s2, bi_s1, bi_s2;
  logic [DW-1:0] ctrl_q, rdata_q;
  logic [3:0] sicr_q [NS];
  logic [3:0] socr_q [NS];
  logic [DW-1:0] cm [MD];
  logic [7:0] dm [2][MD];
  logic [4:0] sub_q;
  logic [BITW-1:0] bit_q;
  logic bank_q;
  logic [7:0] sh_q [NS];
  logic [7:0] pb_q [NS];
  logic [CHW-1:0] pc_q [NS];
  logic [NS-1:0] pk_q, pend_q;
  logic [SW-1:0] rr_q;
  logic [FW-1:0] fb_q [BUF_DEPTH];
  logic [PW-1:0] wp_q, rp_q;
  logic [PW:0] cnt_q;
  tdmsw_blk_e st_q;
  logic [AW-1:0] bidx_q;
  logic [1:0] pat_q;

  // Pin synchronisers
  always_ff @(posedge clk) begin
    ck_s <= {ck_s[1:0], tdm_input_clock};
    fp_s <= {fp_s[1:0], tdm_frame_pulse_in};
    si_s1 <= serial_in_stream;
    si_s2 <= si_s1;
    bi_s1 <= serial_bidir_out_stream_pin;
    bi_s2 <= bi_s1;
  end

  wire [1:0] rate = ctrl_q[CTRL_RATE +: 2];
  wire [2:0] cks = 3'(ctrl_q[CTRL_CKS +: 2]);
  wire conv = ctrl_q[CTRL_CONV];
  wire [BITW-1:0] bmask = BITW'((FRAME_BITS_MIN << rate) - 1);
  logic [2:0] e_log;
  always_comb begin
    e_log = cks + EDGE_LOG_OFS - 3'(rate);
    if (cks + EDGE_LOG_OFS <= 3'(rate) + 3'h1)
      e_log = 3'h1;
  end
  wire [4:0] e_last = 5'((6'h1 << e_log) - 6'h1);
  wire [4:0] e_half = 5'((6'h1 << e_log) >> 1);
  wire tick = ck_s[2] ^ ck_s[1];
  wire fp_now = conv ? fp_s[1] : ~fp_s[1];
  wire fp_was = conv ? fp_s[2] : ~fp_s[2];
  wire fstart = fp_now & ~fp_was;

  // Frame and bit counters
  always_ff @(posedge clk) begin
    if (reset) begin
      sub_q <= '0;
      bit_q <= '0;
      bank_q <= 1'b0;
    end else if (fstart) begin
      sub_q <= {4'h0, conv};
      bit_q <= '0;
      bank_q <= ~bank_q;
    end else if (tick) begin
      if (sub_q >= e_last) begin
        sub_q <= '0;
        bit_q <= (bit_q + BITW'(1)) & bmask;
      end else begin
        sub_q <= sub_q + 5'h1;
      end
    end
  end

  wire [NS-1:0] rx = ctrl_q[CTRL_BIDIR] ? bi_s2 : si_s2;
  logic [BITW-1:0] ib [NS];
  logic [BITW-1:0] ob [NS];
  logic [NS-1:0] smp, done, drv, obit, oen;
  logic [DW-1:0] ce [NS];

  for (genvar s = 0; s < NS; s++) begin : g_str
    wire [7:0] db;
    wire [7:0] ob_byte;
    assign ib[s] = (bit_q - BITW'(sicr_q[s][SI_DLY +: 3])) & bmask;
    assign smp[s] = tick && sub_q == (sicr_q[s][SI_SPT] ? e_last : e_half);
    assign done[s] = smp[s] && ib[s][2:0] == 3'h7;
    assign ob[s] = (bit_q + BITW'(socr_q[s][SO_ADV +: 3]) + BITW'(1))
      & bmask;
    assign drv[s] = tick && sub_q == (socr_q[s][SO_FRC] ? e_half : e_last);
    assign ce[s] = cm[{SW'(s), ob[s][BITW-1:3]}];
    assign db = dm[bank_q ^ ce[s][CM_CONST]]
      [{ce[s][CM_SRC +: SW], ce[s][CM_CH +: CHW]}];
    assign ob_byte = (ce[s][CM_MODE +: 2] == CM_MSG) ? ce[s][7:0] : db;
    assign obit[s] = ob_byte[~ob[s][2:0]];
    assign oen[s] = ce[s][CM_MODE +: 2] != CM_HIZ;
  end

  // Input shifters and per-stream pending bytes
  wire push_v = pend_q[rr_q];
  wire push_r = cnt_q != (PW+1)'(BUF_DEPTH);
  wire accept = push_v & push_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      pend_q <= '0;
      pk_q <= '0;
      rr_q <= '0;
      for (int i = 0; i < NS; i++) begin
        sh_q[i] <= 8'h00;
        pb_q[i] <= 8'h00;
        pc_q[i] <= '0;
      end
    end else begin
      if (!(push_v && !push_r))
        rr_q <= rr_q + SW'(1);
      for (int i = 0; i < NS; i++) begin
        if (smp[i])
          sh_q[i] <= {sh_q[i][6:0], rx[i]};
        if (done[i]) begin
          pend_q[i] <= 1'b1;
          pb_q[i] <= {sh_q[i][6:0], rx[i]};
          pc_q[i] <= ib[i][BITW-1:3];
          pk_q[i] <= bank_q;
        end else if (accept && rr_q == SW'(i)) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // Two-entry buffer in front of the data memory write port
  wire is_mem = addr[ADR_MEM];
  wire is_dm = is_mem & addr[ADR_DM];
  wire is_cm = is_mem & ~addr[ADR_DM];
  wire [AW-1:0] midx = addr[AW-1:0];
  wire pop_v = cnt_q != '0;
  wire pop_r = ~(re & is_dm);
  wire [FW-1:0] pop_d = fb_q[rp_q];
  always_ff @(posedge clk) begin
    if (reset) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (accept) begin
        fb_q[wp_q] <= {pk_q[rr_q], rr_q, pc_q[rr_q], pb_q[rr_q]};
        wp_q <= wp_q + PW'(1);
      end
      if (pop_v && pop_r)
        rp_q <= rp_q + PW'(1);
      cnt_q <= cnt_q + (PW+1)'(accept) - (PW+1)'(pop_v && pop_r);
    end
  end

  always_ff @(posedge clk) begin
    if (pop_v && pop_r)
      dm[pop_d[FW-1]][pop_d[8 +: AW]] <= pop_d[7:0];
  end

  // Host registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= CTRL_RST;
      for (int i = 0; i < NS; i++) begin
        sicr_q[i] <= SCR_RST;
        socr_q[i] <= SCR_RST;
      end
    end else if (we && !is_mem) begin
      if (addr == REG_CTRL)
        ctrl_q <= wdata;
      if (addr[ADRW-1:STR_W] == REG_SICR[ADRW-1:STR_W])
        sicr_q[addr[STR_W-1:0]] <= wdata[3:0];
      if (addr[ADRW-1:STR_W] == REG_SOCR[ADRW-1:STR_W])
        socr_q[addr[STR_W-1:0]] <= wdata[3:0];
    end
  end

  // Block programming sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= BLK_IDLE;
      bidx_q <= '0;
      pat_q <= CM_HIZ;
    end else begin
      case (st_q)
        BLK_IDLE: begin
          if (we && !is_mem && addr == REG_BLK && wdata[BLK_GO]) begin
            st_q <= BLK_RUN;
            pat_q <= wdata[BLK_PAT +: 2];
            bidx_q <= '0;
          end
        end
        BLK_RUN: begin
          bidx_q <= bidx_q + AW'(1);
          if (&bidx_q)
            st_q <= BLK_IDLE;
        end
        default: st_q <= BLK_IDLE;
      endcase
    end
  end

  // Connection memory: reset to high impedance, block fill, host writes
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < MD; i++)
        cm[i] <= {CM_HIZ, 14'h0000};
    end else if (st_q == BLK_RUN) begin
      cm[bidx_q] <= {pat_q, 14'h0000};
    end else if (we && is_cm) begin
      cm[midx] <= wdata;
    end
  end

  // Read port; data memory is readable but never host-written
  always_ff @(posedge clk) begin
    if (reset || !re) begin
      rdata_q <= '0;
    end else if (is_dm) begin
      rdata_q <= {8'h00, dm[~bank_q][midx]};
    end else if (is_cm) begin
      rdata_q <= cm[midx];
    end else if (addr == REG_CTRL) begin
      rdata_q <= ctrl_q;
    end else if (addr == REG_STAT) begin
      rdata_q <= '0;
      rdata_q[STAT_BANK] <= bank_q;
      rdata_q[STAT_BUSY] <= st_q == BLK_RUN;
    end else if (addr[ADRW-1:STR_W] == REG_SICR[ADRW-1:STR_W]) begin
      rdata_q <= {12'h000, sicr_q[addr[STR_W-1:0]]};
    end else if (addr[ADRW-1:STR_W] == REG_SOCR[ADRW-1:STR_W]) begin
      rdata_q <= {12'h000, socr_q[addr[STR_W-1:0]]};
    end else begin
      rdata_q <= '0;
    end
  end
  assign rdata = rdata_q;

  // Output drivers
  logic [NS-1:0] so_q, oe_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      so_q <= '0;
      oe_q <= '0;
    end else begin
      for (int i = 0; i < NS; i++) begin
        if (drv[i]) begin
          so_q[i] <= obit[i];
          oe_q[i] <= oen[i];
        end
      end
    end
  end
  assign serial_bidir_out_stream = so_q;
  assign serial_bidir_out_stream_en = oe_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [15:0] bcnt_q;
  always_ff @(posedge clk)
    bcnt_q <= (st_q == BLK_RUN) ? bcnt_q + 16'h1 : 16'h0;

  hiz_driver_a: assert property (drv[0] && !oen[0] |=> !oe_q[0])
    else $error("hiz slot still driven");
  msg_byte_a: assert property (drv[0]
    && ce[0][CM_MODE +: 2] == CM_MSG
    |=> so_q[0] == $past(ce[0][~ob[0][2:0]]))
    else $error("message bit wrong");
  cm_readback_a: assert property (we && is_cm
    && st_q == BLK_IDLE ##1 !we
    ##1 re && addr == $past(addr, 2) |=> rdata == $past(wdata, 3))
    else $error("connection entry not stored");
  frame_bound_a: assert property ((bit_q & ~bmask) == '0)
    else $error("bit counter outside frame");
  blk_length_a: assert property (bcnt_q <= 16'(MD))
    else $error("block fill overran");
  blk_pattern_a: assert property (st_q == BLK_RUN && &bidx_q
    |=> st_q == BLK_IDLE && cm[MD-1][CM_MODE +: 2] == $past(pat_q))
    else $error("block fill wrong end");
  buf_bound_a: assert property (cnt_q <= (PW+1)'(BUF_DEPTH))
    else $error("buffer overfilled");
  dm_read_stall_a: assert property (re && is_dm && pop_v
    |=> rp_q == $past(rp_q))
    else $error("write popped during host read");
  rd_idle_a: assert property (!re |=> rdata == '0)
    else $error("read data outside slot");
  bidir_src_a: assert property (ctrl_q[CTRL_BIDIR] && smp[0]
    |=> sh_q[0][0] == $past(bi_s2[0]))
    else $error("wrong input source");

  blk_run_c: cover property (st_q == BLK_RUN ##1 st_q == BLK_IDLE);
  buf_full_c: cover property (cnt_q == (PW+1)'(BUF_DEPTH));
  msg_send_c: cover property (drv[0] && ce[0][CM_MODE +: 2] == CM_MSG);
  frame_c: cover property (fstart);
endmodule

// >>> inc/tdmsw_pkg.sv
// Constants and types for the TDM time-slot switch
package tdmsw_pkg;
  localparam int NSTR = 16;
  localparam int CHW = 8;
  localparam int BITW = 11;
  localparam int ADRW = 14;
  localparam int DW = 16;
  localparam int BUF_DEPTH = 2;
  // Address decode
  localparam int ADR_MEM = 13;
  localparam int ADR_DM = 12;
  localparam int STR_W = 4;
  localparam logic [13:0] REG_CTRL = 14'h0000;
  localparam logic [13:0] REG_BLK = 14'h0001;
  localparam logic [13:0] REG_STAT = 14'h0002;
  localparam logic [13:0] REG_SICR = 14'h0010;
  localparam logic [13:0] REG_SOCR = 14'h0020;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  // Control fields
  localparam int CTRL_RATE = 0;
  localparam int CTRL_CKS = 2;
  localparam int CTRL_CONV = 4;
  localparam int CTRL_BIDIR = 5;
  localparam int BLK_GO = 0;
  localparam int BLK_PAT = 1;
  localparam int STAT_BANK = 0;
  localparam int STAT_BUSY = 1;
  // Per-stream fields
  localparam int SI_DLY = 0;
  localparam int SI_SPT = 3;
  localparam int SO_ADV = 0;
  localparam int SO_FRC = 3;
  localparam logic [3:0] SCR_RST = 4'h0;
  // Connection memory entry fields
  localparam int CM_MODE = 14;
  localparam int CM_CONST = 13;
  localparam int CM_SRC = 8;
  localparam int CM_CH = 0;
  localparam logic [1:0] CM_CONN = 2'h0;
  localparam logic [1:0] CM_MSG = 2'h1;
  localparam logic [1:0] CM_HIZ = 2'h2;
  // Frame timing
  localparam int FRAME_BITS_MIN = 256;
  localparam logic [2:0] EDGE_LOG_OFS = 3'h2;
  typedef enum logic {BLK_IDLE, BLK_RUN} tdmsw_blk_e;
endpackage

// >>> test/tdmsw_framer_model.sv
// Behavioural TDM framer: clock, frame pulse and serial input streams
`timescale 1ns/1ps
module tdmsw_framer_model (
  output logic tdm_input_clock,
  output logic tdm_frame_pulse_in,
  output logic [15:0] serial_in_stream,
  output logic [7:0] bit_idx,
  output logic bit_mid
);
  // Byte sent on stream s, channel c in every frame
  function automatic logic [7:0] pat(input int s, input int c);
    return 8'(s * 16) ^ 8'(c) ^ 8'h81;
  endfunction
  initial begin
    logic [7:0] v;
    tdm_input_clock = 1'b0;
    tdm_frame_pulse_in = 1'b1;
    serial_in_stream = '0;
    bit_idx = '0;
    bit_mid = 1'b0;
    forever begin
      for (int b = 0; b < 256; b++) begin
        bit_idx = 8'(b);
        for (int s = 0; s < 16; s++) begin
          v = pat(s, b / 8);
          serial_in_stream[s] = v[7 - b % 8];
        end
        tdm_frame_pulse_in = (b != 0);
        #400 tdm_input_clock = 1'b1;
        #400 tdm_input_clock = 1'b0;
        tdm_frame_pulse_in = 1'b1;
        bit_mid = 1'b1;
        #400 tdm_input_clock = 1'b1;
        bit_mid = 1'b0;
        #400 tdm_input_clock = 1'b0;
      end
    end
  end
endmodule

// >>> test/tb_top.sv
// Testbench for the TDM time-slot switch
`timescale 1ns/1ps
module tb_top;
  import tdmsw_pkg::*;
  typedef struct {logic wr; logic [13:0] a; logic [15:0] d, e;} tdmsw_row_s;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [13:0] addr = '0;
  logic [15:0] wdata = '0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [15:0] rdata, v, eb;
  logic tck, tfp, bit_mid;
  logic [7:0] bidx;
  logic [15:0] sin, sout, sen, spin;
  logic [4:0] ch;
  logic [2:0] k;
  int err_total = 0;
  int check_count = 0;
  tdmsw_row_s rows [14];
  always #50 clk = ~clk;
  assign spin = (sout & sen) | ~sen;
  tdmsw_core DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .we(we), .re(re), .rdata(rdata), .tdm_input_clock(tck),
    .tdm_frame_pulse_in(tfp), .serial_in_stream(sin),
    .serial_bidir_out_stream_pin(spin), .serial_bidir_out_stream(sout),
    .serial_bidir_out_stream_en(sen));
  tdmsw_framer_model u_far (.tdm_input_clock(tck),
    .tdm_frame_pulse_in(tfp), .serial_in_stream(sin), .bit_idx(bidx),
    .bit_mid(bit_mid));
  function automatic logic [13:0] ma(input logic dm, input int s, c);
    return {1'b1, dm, 4'(s), 8'(c)};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [13:0] a, output logic [15:0] d);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #5000000;
    err_total++;
    wrap_up();
  end
  initial begin
    rows = '{'{1, REG_CTRL, 16'h0000, 16'h0},
      '{0, REG_CTRL, 16'h0, 16'h0000},
      '{1, REG_SICR + 14'hf, 16'hffff, 16'h0},
      '{0, REG_SICR + 14'hf, 16'h0, 16'h000f},
      '{1, REG_SOCR + 14'hf, 16'h0009, 16'h0},
      '{0, REG_SOCR + 14'hf, 16'h0, 16'h0009},
      '{0, 14'h0003, 16'h0, 16'h0000},
      '{1, ma(1, 0, 5), 16'h00ff, 16'h0},
      '{1, ma(0, 1, 3), 16'h0005, 16'h0},
      '{0, ma(0, 1, 3), 16'h0, 16'h0005},
      '{1, ma(0, 4, 3), 16'h2005, 16'h0},
      '{0, ma(0, 4, 3), 16'h0, 16'h2005},
      '{1, ma(0, 2, 7), 16'h403c, 16'h0},
      '{0, ma(0, 2, 7), 16'h0, 16'h403c}};
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 chk("rdata_rst", 16'h0, rdata);
    chk("en_rst", 16'h0, sen);
    $display("test reset done");
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].a, rows[i].d);
      end else begin
        rd(rows[i].a, v);
        chk("reg_row", rows[i].e, v);
      end
    end
    $display("test register rows done");
    repeat (3 * 4096) @(posedge clk);
    rd(ma(1, 0, 5), v);
    chk("dm_s0_c5", {8'h0, u_far.pat(0, 5)}, v);
    rd(ma(1, 9, 31), v);
    chk("dm_s9_c31", {8'h0, u_far.pat(9, 31)}, v);
    $display("test data memory done");
    do @(posedge bit_mid); while (bidx !== 8'h00);
    for (int b = 0; b < 256; b++) begin
      if (b > 0) @(posedge bit_mid);
      ch = bidx[7:3];
      k = 3'h7 - bidx[2:0];
      if (ch == 5'd3) begin
        eb = 16'(u_far.pat(0, 5) >> k & 8'h1);
        chk("conn_en", 16'h3, {14'h0, sen[4], sen[1]});
        chk("conn_bit", eb, {15'h0, sout[1]});
        chk("const_bit", eb, {15'h0, sout[4]});
      end
      if (ch == 5'd7) begin
        chk("msg_en", 16'h1, {15'h0, sen[2]});
        chk("msg_bit", 16'(8'h3c >> k & 8'h1), {15'h0, sout[2]});
      end
      if (ch == 5'd4) chk("hiz_en", 16'h0, {14'h0, sen[3], sen[1]});
    end
    $display("test output frame done");
    wr(REG_BLK, 16'h0003);
    v = 16'h2;
    for (int n = 0; n < 5000 && v[STAT_BUSY] !== 1'b0; n++) rd(REG_STAT, v);
    chk("blk_busy", 16'h0, {15'h0, v[STAT_BUSY]});
    rd(ma(0, 1, 3), v);
    chk("blk_fill", 16'h4000, v);
    $display("test block programming done");
    wr(ma(0, 0, 5), 16'h405a);
    wr(REG_CTRL, 16'h0020);
    repeat (3 * 4096) @(posedge clk);
    rd(ma(1, 0, 5), v);
    chk("bidir_s0_c5", 16'h005a, v);
    rd(ma(1, 9, 31), v);
    chk("bidir_s9_c31", 16'h0000, v);
    $display("test bidirectional input done");
    wrap_up();
  end
endmodule
